// ==== hw/sdb_baud_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdb_defines.svh"
module sdb_baud_gen (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire sdb_pkg::sdb_req_s bus_req,
	output sdb_pkg::sdb_rsp_s bus_rsp,
	input wire logic crystal_clock_tick,
	input wire logic baud_source_select,
	input wire logic char_len_select,
	input wire logic tx_take,
	output logic tx_valid,
	output logic [7:0] tx_byte_out,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte_in,
	output logic rx_ready,
	output logic bit_tick,
	output logic sample_tick,
	output logic [4:0] rx_break_bits,
	output logic [4:0] tx_break_bits,
	output logic lin_break_transmit_select,
	output logic lin_break_receive_select
);
	import sdb_pkg::*;

	typedef struct packed {
		sdb_rsp_s rsp;
		sdb_bus_e bus;
		sdb_baud_s baud;
		sdb_psc_s psc;
		logic [7:0] rx_byte;
		logic [1:0][7:0] txb;
		logic [1:0] txv;
		logic [3:0] coarse_cnt; // Must reach 12 for the divide by 13
		logic [3:0] int_cnt; // Must reach 8 when code 111 takes an insert
		logic frac_extra;
		logic [4:0] frame_cnt;
		logic [4:0] frac_acc;
		logic [6:0] rate_cnt;
		logic [5:0] os_cnt;
		logic bit_q;
		logic samp_q;
		logic tx_valid;
		logic [7:0] tx_out;
		logic rx_ready;
		logic [4:0] rxb;
		logic [4:0] txbk;
	} sdb_state_s;

	sdb_state_s s_q;
	sdb_state_s s_d;

	// Coarse prescaler code to terminal count (divisor minus one)
	function automatic logic [3:0] coarse_top(input logic [1:0] code);
		case (code)
			2'h0: coarse_top = 4'h0;
			2'h1: coarse_top = 4'h2;
			2'h2: coarse_top = 4'h3;
			default: coarse_top = 4'hC;
		endcase
	endfunction

	logic src_tick;
	logic [3:0] coarse_cnt4;
	logic pre_tick;
	logic int_tick;
	logic coarse_tick;
	logic [6:0] rate_top;
	logic acc_wrap;
	logic [5:0] acc_sum;

	// Source mux: bus clock is every cycle, crystal arrives as an enable
	assign src_tick = baud_source_select ? crystal_clock_tick : 1'b1;
	// Rate divisor is two to the code
	assign rate_top = 7'((8'h01 << s_q.baud.rate) - 8'h01);
	assign acc_sum = {1'b0, s_q.frac_acc} + {1'b0, s_q.psc.frac};
	assign acc_wrap = acc_sum[5];

	always_comb begin
		s_d = s_q;
		s_d.bit_q = 1'b0;
		s_d.samp_q = 1'b0;
		pre_tick = 1'b0;
		int_tick = 1'b0;
		coarse_tick = 1'b0;
		coarse_cnt4 = s_q.coarse_cnt;

		// Integer divisor stage with fractional insertion; 000 bypasses both
		if (src_tick) begin
			if (s_q.psc.integer_div == 3'h0) begin
				pre_tick = 1'b1;
			end else if (s_q.int_cnt < ({1'b0, s_q.psc.integer_div} + {3'h0, s_q.frac_extra})) begin
				// Compared in four bits so that 7 plus an insert does not wrap to 0
				s_d.int_cnt = 4'(s_q.int_cnt + 4'h1);
			end else begin
				pre_tick = 1'b1;
				s_d.int_cnt = 4'h0;
				// Accumulator spreads N inserts evenly over a 32-output frame
				s_d.frame_cnt = 5'(s_q.frame_cnt + 5'h01);
				s_d.frac_acc = acc_sum[4:0];
				s_d.frac_extra = acc_wrap;
				if (s_q.frame_cnt == `SDB_FRAME_LEN) begin
					s_d.frac_acc = 5'h00;
				end
			end
		end
		// Bypass drops any pending insert, so leaving bypass starts a clean frame
		if (s_q.psc.integer_div == 3'h0) begin
			s_d.int_cnt = 4'h0;
			s_d.frac_extra = 1'b0;
			s_d.frac_acc = 5'h00;
			s_d.frame_cnt = 5'h00;
		end
		// Coarse prescaler
		if (pre_tick) begin
			if (coarse_cnt4 >= coarse_top(s_q.baud.coarse)) begin
				s_d.coarse_cnt = 4'h0;
				coarse_tick = 1'b1;
			end else begin
				s_d.coarse_cnt = 4'(s_q.coarse_cnt + 4'h1);
			end
		end
		// Rate divisor, then 64x oversample shared by rx and tx
		if (coarse_tick) begin
			if (s_q.rate_cnt >= rate_top) begin
				s_d.rate_cnt = 7'h00;
				int_tick = 1'b1;
			end else begin
				s_d.rate_cnt = 7'(s_q.rate_cnt + 7'h01);
			end
		end
		if (int_tick) begin
			s_d.samp_q = s_q.os_cnt[3:0] == 4'hF;
			s_d.os_cnt = 6'(s_q.os_cnt + 6'h01);
			s_d.bit_q = s_q.os_cnt == 6'h3F;
		end

		// Break lengths: zero means normal operation
		s_d.rxb = s_q.baud.rx_break_sel ? 5'(`SDB_RX_BRK_BASE + {4'h0, char_len_select}) : 5'h00;
		s_d.txbk = s_q.baud.tx_break_sel ? 5'(`SDB_TX_BRK_BASE + {4'h0, char_len_select}) : 5'h00;

		// Two-entry transmit buffer; the shifter drains entry 0
		if (s_q.tx_valid && tx_take) begin
			s_d.txv = {1'b0, s_q.txv[1]};
			s_d.txb[0] = s_q.txb[1];
		end
		s_d.tx_valid = s_d.txv[0];
		s_d.tx_out = s_d.txb[0];
		// Receive holding byte, overwritten only by the receiver
		if (rx_valid && s_q.rx_ready) begin
			s_d.rx_byte = rx_byte_in;
		end
		s_d.rx_ready = 1'b1;

		// Avalon slave: one wait cycle, then answer
		s_d.rsp.waitrequest = 1'b1;
		case (s_q.bus)
			SDB_IDLE: begin
				if (bus_req.read || bus_req.write) begin
					s_d.bus = SDB_DONE;
					s_d.rsp.waitrequest = 1'b0;
					s_d.rsp.readdata = 32'h0;
					case (bus_req.address)
						`SDB_OFS_DATA: begin
							// Read side and write side are separate storage
							s_d.rsp.readdata = {24'h0, s_q.rx_byte};
							if (bus_req.write) begin
								if (!s_d.txv[0]) begin
									s_d.txv[0] = 1'b1;
									s_d.txb[0] = bus_req.writedata[7:0];
								end else if (!s_d.txv[1]) begin
									s_d.txv[1] = 1'b1;
									s_d.txb[1] = bus_req.writedata[7:0];
								end else begin
									// Full: stall the master until the shifter frees a slot
									s_d.bus = SDB_IDLE;
									s_d.rsp.waitrequest = 1'b1;
								end
							end
						end
						`SDB_OFS_BAUD: begin
							s_d.rsp.readdata = {24'h0, s_q.baud};
							if (bus_req.write) begin
								s_d.baud = bus_req.writedata[7:0];
								s_d.baud.pad = 1'h0;
							end
						end
						`SDB_OFS_PSC: begin
							s_d.rsp.readdata = {24'h0, s_q.psc};
							if (bus_req.write) begin
								s_d.psc = bus_req.writedata[7:0];
							end
						end
						`SDB_OFS_LINK: begin
							s_d.rsp.readdata = {30'h0, s_q.txv};
						end
						default: begin
							s_d.rsp.readdata = 32'h0;
						end
					endcase
				end
			end
			SDB_DONE: begin
				s_d.bus = SDB_IDLE;
			end
			default: begin
				s_d.bus = SDB_IDLE;
			end
		endcase
		s_d.tx_valid = s_d.txv[0];
		s_d.tx_out = s_d.txb[0];
	end

	// The receive byte and the transmit buffer bytes are deliberately left out of reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q.rsp <= '{readdata: 32'h0, waitrequest: 1'b1};
			s_q.bus <= SDB_IDLE;
			s_q.baud <= 8'h00;
			s_q.psc <= 8'h00;
			s_q.txv <= 2'h0;
			s_q.coarse_cnt <= 4'h0;
			s_q.int_cnt <= 4'h0;
			s_q.frac_extra <= 1'b0;
			s_q.frame_cnt <= 5'h00;
			s_q.frac_acc <= 5'h00;
			s_q.rate_cnt <= 7'h00;
			s_q.os_cnt <= 6'h00;
			s_q.bit_q <= 1'b0;
			s_q.samp_q <= 1'b0;
			s_q.tx_valid <= 1'b0;
			s_q.tx_out <= 8'h00;
			s_q.rx_ready <= 1'b0;
			s_q.rxb <= 5'h00;
			s_q.txbk <= 5'h00;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_rsp = s_q.rsp;
	assign tx_valid = s_q.tx_valid;
	assign tx_byte_out = s_q.tx_out;
	assign rx_ready = s_q.rx_ready;
	assign bit_tick = s_q.bit_q;
	assign sample_tick = s_q.samp_q;
	assign rx_break_bits = s_q.rxb;
	assign tx_break_bits = s_q.txbk;
	assign lin_break_transmit_select = s_q.baud.tx_break_sel;
	assign lin_break_receive_select = s_q.baud.rx_break_sel;

	// Break length follows the select and character length
	a_rx_break_len: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_q.baud.rx_break_sel |=> (rx_break_bits == 5'h0B || rx_break_bits == 5'h0C))
		else $error("rx break length wrong");
	a_tx_break_len: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.baud.tx_break_sel && !char_len_select) |=> tx_break_bits == 5'h0D)
		else $error("tx break length wrong");
	// Long character length lengthens the generated break by one bit
	a_tx_break_long: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.baud.tx_break_sel && char_len_select) |=> tx_break_bits == 5'h0E)
		else $error("long tx break length wrong");
	a_normal_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!s_q.baud.tx_break_sel && !s_q.baud.rx_break_sel)
		|=> (rx_break_bits == 5'h00 && tx_break_bits == 5'h00))
		else $error("break active in normal mode");
	// Receive select alone must not leak into the transmit length, nor the reverse
	a_rx_only_off: assert property (@(posedge sys_clk) disable iff (!nrst)
		!s_q.baud.rx_break_sel |=> rx_break_bits == 5'h00)
		else $error("rx break length without select");
	a_tx_only_off: assert property (@(posedge sys_clk) disable iff (!nrst)
		!s_q.baud.tx_break_sel |=> tx_break_bits == 5'h00)
		else $error("tx break length without select");
	a_both_modes: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.baud.tx_break_sel && s_q.baud.rx_break_sel && char_len_select)
		|=> (rx_break_bits == 5'h0C && tx_break_bits == 5'h0E))
		else $error("combined break lengths wrong");
	// Short character length with both selects gives the 11 and 13 pair
	a_both_short: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.baud.tx_break_sel && s_q.baud.rx_break_sel && !char_len_select)
		|=> (rx_break_bits == 5'h0B && tx_break_bits == 5'h0D))
		else $error("short combined break lengths wrong");
	// A register write lands in the cycle after the slave takes it
	a_baud_lands: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.bus == SDB_IDLE && bus_req.write && bus_req.address == `SDB_OFS_BAUD)
		|=> s_q.baud == $past({bus_req.writedata[7:6], 1'b0, bus_req.writedata[4:0]}))
		else $error("baud write lost");
	a_psc_lands: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.bus == SDB_IDLE && bus_req.write && bus_req.address == `SDB_OFS_PSC)
		|=> s_q.psc == $past(bus_req.writedata[7:0]))
		else $error("prescaler write lost");
	a_bypass_tick: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.psc.integer_div == 3'h0 && src_tick) |-> pre_tick)
		else $error("bypass did not pass clock");
	a_int_div: assert property (@(posedge sys_clk) disable iff (!nrst)
		(pre_tick && s_q.psc.integer_div != 3'h0) |-> ##1 !pre_tick)
		else $error("integer divisor too fast");
	a_coarse_one: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.baud.coarse == 2'h0 && pre_tick) |-> coarse_tick)
		else $error("coarse divide by one failed");
	a_rate_one: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.baud.rate == 3'h0 && coarse_tick) |-> int_tick)
		else $error("rate divide by one failed");
	// A zero fraction can never wrap the accumulator
	a_frac_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.psc.frac == 5'h00 && pre_tick && s_q.psc.integer_div != 3'h0) |=> !s_q.frac_extra)
		else $error("insert without fraction");
	// Bypass must carry no leftover insert
	a_frac_bypass: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_q.psc.integer_div == 3'h0 |=> !s_q.frac_extra)
		else $error("insert pending in bypass");
	// The end of a 32-output frame restarts the accumulator
	a_frame_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.frame_cnt == `SDB_FRAME_LEN && pre_tick && s_q.psc.integer_div != 3'h0)
		|=> s_q.frac_acc == 5'h00)
		else $error("frame accumulator not restarted");
	// Counters stay inside the longest divisor they serve
	a_int_cnt_max: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_q.int_cnt <= 4'h8)
		else $error("integer counter overran");
	a_coarse_max: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_q.coarse_cnt <= 4'hC)
		else $error("coarse counter overran");
	// Every bit tick is also a sample tick, and both are single pulses
	a_sample_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
		bit_tick |-> sample_tick)
		else $error("bit tick without sample tick");
	a_bit_gap: assert property (@(posedge sys_clk) disable iff (!nrst)
		bit_tick |=> !bit_tick)
		else $error("bit tick longer than one cycle");
	a_sample_gap: assert property (@(posedge sys_clk) disable iff (!nrst)
		sample_tick |=> !sample_tick)
		else $error("sample tick longer than one cycle");
	a_os_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
		bit_tick |-> s_q.os_cnt == 6'h00)
		else $error("oversample count off at bit tick");
	// Receive path takes exactly what the receiver offered
	a_rx_take: assert property (@(posedge sys_clk) disable iff (!nrst)
		(rx_valid && rx_ready) |=> s_q.rx_byte == $past(rx_byte_in))
		else $error("receive byte not taken");
	a_data_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		!(rx_valid && rx_ready) |=> s_q.rx_byte === $past(s_q.rx_byte))
		else $error("receive byte changed without data");
	a_rx_ready_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		rx_ready |=> rx_ready)
		else $error("receive ready dropped");
	// A stalled shifter must see the same head byte until it takes it
	a_tx_head_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		(tx_valid && !tx_take) |=> (tx_valid && $stable(tx_byte_out)))
		else $error("transmit head changed while stalled");
	a_tx_second: assert property (@(posedge sys_clk) disable iff (!nrst)
		(tx_valid && tx_take && s_q.txv[1]) |=> tx_valid)
		else $error("second transmit entry lost");
	// A data write into a full buffer is held off, not dropped
	a_full_stall: assert property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.bus == SDB_IDLE && bus_req.write && bus_req.address == `SDB_OFS_DATA
		&& s_q.txv == 2'h3 && !tx_take) |=> bus_rsp.waitrequest)
		else $error("write accepted into full buffer");
	// The answer stands one cycle and carries only the byte lane
	a_wait_one: assert property (@(posedge sys_clk) disable iff (!nrst)
		!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
		else $error("answer stood longer than one cycle");
	a_readdata_hi: assert property (@(posedge sys_clk) disable iff (!nrst)
		!bus_rsp.waitrequest |-> bus_rsp.readdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
endmodule
`default_nettype wire

// ==== hw/sdb_defines.svh ====
`ifndef SDB_DEFINES_SVH
`define SDB_DEFINES_SVH
`define SDB_OFS_DATA 16'h0015
`define SDB_OFS_BAUD 16'h0016
`define SDB_OFS_PSC 16'h0017
`define SDB_OFS_LINK 16'h0018
`define SDB_BAUD_TX_SEL 7
`define SDB_BAUD_RX_SEL 6
`define SDB_OVERSAMPLE 7'h40
`define SDB_FRAME_LEN 5'h1F
`define SDB_RX_BRK_BASE 5'h0B
`define SDB_TX_BRK_BASE 5'h0D
`define SDB_STATUS_LOAD_BIT 0
`endif

// ==== hw/sdb_pkg.sv ====
package sdb_pkg;
	typedef struct packed {
		logic [15:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} sdb_req_s;
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} sdb_rsp_s;
	typedef struct packed {
		logic tx_break_sel;
		logic rx_break_sel;
		logic pad;
		logic [1:0] coarse;
		logic [2:0] rate;
	} sdb_baud_s;
	typedef struct packed {
		logic [2:0] integer_div;
		logic [4:0] frac;
	} sdb_psc_s;
	typedef enum logic [1:0] {
		SDB_IDLE,
		SDB_DONE
	} sdb_bus_e;
endpackage

// ==== test/sdb_baud_gen_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdb_defines.svh"
module sdb_baud_gen_tb_top;
	import sdb_pkg::*;
	logic sys_clk = 0, nrst = 0, xtal = 0, src = 0, clen = 0, stall = 1, rx_send = 0;
	logic tx_take, tx_valid, rx_valid, rx_ready, bit_tick, samp, tx_sel, rx_sel;
	logic [7:0] tx_byte_out, rx_byte_in, got_last, rx_data = 8'h00;
	logic [4:0] rx_break_bits, tx_break_bits;
	logic [31:0] q;
	int got_cnt, n_fail = 0, checked = 0, n_samp = 0;
	sdb_req_s bus_req = '0;
	sdb_rsp_s bus_rsp;
	sdb_baud_gen dut_u (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp),
		.crystal_clock_tick(xtal), .baud_source_select(src), .char_len_select(clen),
		.tx_take(tx_take), .tx_valid(tx_valid), .tx_byte_out(tx_byte_out), .rx_valid(rx_valid),
		.rx_byte_in(rx_byte_in), .rx_ready(rx_ready), .bit_tick(bit_tick), .sample_tick(samp),
		.rx_break_bits(rx_break_bits), .tx_break_bits(tx_break_bits),
		.lin_break_transmit_select(tx_sel), .lin_break_receive_select(rx_sel));
	sdb_far_model far_u (.sys_clk(sys_clk), .nrst(nrst), .stall(stall), .tx_valid(tx_valid),
		.tx_byte_out(tx_byte_out), .tx_take(tx_take), .rx_send(rx_send), .rx_data(rx_data),
		.rx_ready(rx_ready), .rx_valid(rx_valid), .rx_byte_in(rx_byte_in), .got_cnt(got_cnt),
		.got_last(got_last));
	// Clock, and a crystal enable every second cycle
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) xtal <= ~xtal;
	// Running count of sample ticks, read as a difference across one bit
	always @(posedge sys_clk) if (samp === 1'b1) n_samp <= n_samp + 1;
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, s);
		end
	endtask
	// One Avalon access; held until waitrequest is seen low, then one idle cycle
	task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		bus_req <= '{address:a, read:!w, write:w, writedata:{24'h000000, d}};
		do begin
			@(posedge sys_clk);
			n++;
		end while (bus_rsp.waitrequest !== 1'b0 && n < 5000);
		if (n >= 5000) begin
			n_fail++;
			give_verdict;
		end
		q = bus_rsp.readdata;
		bus_req <= '0;
		@(posedge sys_clk);
	endtask
	task tick(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (bit_tick !== 1'b1 && n < 30000);
	endtask
	// Program a setting, skip two ticks to settle, then time one bit
	task period(input logic [7:0] b, input logic [7:0] p, input logic s, input int e);
		int n;
		int s0;
		bus(1, `SDB_OFS_BAUD, b);
		bus(1, `SDB_OFS_PSC, p);
		src <= s;
		tick(n);
		tick(n);
		s0 = n_samp;
		tick(n);
		chk("bit period", n, e);
		chk("samples per bit", n_samp - s0, 4);
	endtask
	task give_verdict;
		if (n_fail == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge sys_clk);
		n_fail++;
		give_verdict;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1;
		@(posedge sys_clk);
		bus(0, `SDB_OFS_BAUD, 8'h00);
		chk("baud reset", q, 0);
		bus(0, `SDB_OFS_PSC, 8'h00);
		chk("psc reset", q, 0);
		bus(1, 16'h0040, 8'hFF);
		bus(0, 16'h0040, 8'h00);
		chk("unmapped", q, 0);
		// Every select and length combination
		for (int i = 0; i < 8; i++) begin
			bus(1, `SDB_OFS_BAUD, {i[2], i[1], 6'h00});
			clen <= i[0];
			repeat (2) @(posedge sys_clk);
			chk("rx break", rx_break_bits, i[1] ? 11 + i[0] : 0);
			chk("tx break", tx_break_bits, i[2] ? 13 + i[0] : 0);
			chk("selects", {tx_sel, rx_sel}, i[2:1]);
			bus(0, `SDB_OFS_BAUD, 8'h00);
			chk("baud rb", q, {i[2], i[1], 6'h00});
		end
		clen <= 0;
		period(8'h00, 8'h00, 0, 64);
		period(8'h18, 8'h00, 0, 832);
		period(8'h0A, 8'h00, 0, 768);
		period(8'h11, 8'h00, 0, 512);
		period(8'h07, 8'h00, 0, 8192);
		period(8'h00, 8'h20, 0, 128);
		period(8'h00, 8'hF0, 0, 544);
		period(8'h00, 8'h3F, 0, 190);
		period(8'h00, 8'h00, 1, 128);
		src <= 0;
		// Fill the transmit buffer against a stalled shifter; data accesses are never merged
		bus(1, `SDB_OFS_DATA, 8'hA5);
		bus(1, `SDB_OFS_DATA, 8'h5A);
		bus(0, `SDB_OFS_LINK, 8'h00);
		chk("tx occupied", q, 3);
		fork
			bus(1, `SDB_OFS_DATA, 8'h3C);
			begin
				repeat (20) @(posedge sys_clk);
				chk("tx head", tx_byte_out, 8'hA5);
				chk("taken early", got_cnt, 0);
				stall <= 0;
			end
		join
		repeat (20) @(posedge sys_clk);
		chk("tx count", got_cnt, 3);
		chk("tx last", got_last, 8'h3C);
		rx_data <= 8'hC3;
		rx_send <= 1;
		@(posedge sys_clk);
		rx_send <= 0;
		repeat (4) @(posedge sys_clk);
		bus(0, `SDB_OFS_DATA, 8'h00);
		chk("rx byte", q, 8'hC3);
		// Reset in mid-run keeps the data but clears the controls
		nrst <= 0;
		repeat (6) @(posedge sys_clk);
		nrst <= 1;
		@(posedge sys_clk);
		bus(0, `SDB_OFS_DATA, 8'h00);
		chk("rx kept", q, 8'hC3);
		bus(0, `SDB_OFS_PSC, 8'h00);
		chk("psc cleared", q, 0);
		give_verdict;
	end
endmodule
`default_nettype wire

// ==== test/sdb_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdb_far_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic stall,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte_out,
	output logic tx_take,
	input wire logic rx_send,
	input wire logic [7:0] rx_data,
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [7:0] rx_byte_in,
	output int got_cnt,
	output logic [7:0] got_last
);
	// Shifter side: takes one byte per two cycles, stalls on request; idle data toggles
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tx_take <= 1'b0;
			rx_valid <= 1'b0;
			rx_byte_in <= 8'h00;
			got_cnt <= 0;
			got_last <= 8'h00;
		end else begin
			tx_take <= tx_valid && !stall && !tx_take;
			if (tx_take && tx_valid) begin
				got_cnt <= got_cnt + 1;
				got_last <= tx_byte_out;
			end
			if (rx_valid && rx_ready) begin
				rx_valid <= 1'b0;
				rx_byte_in <= ~rx_byte_in;
			end else if (rx_send && !rx_valid) begin
				rx_valid <= 1'b1;
				rx_byte_in <= rx_data;
			end else if (!rx_valid) begin
				rx_byte_in <= ~rx_byte_in; // Released data must not look stable
			end
		end
	end
endmodule
`default_nettype wire
